// file: src/tpm_core.sv
// tpm_core: register file, map-load control and pattern insertion
// assumes: registers written by the serial control port decoder on
// ref_clk; converter samples arrive on ref_clk; the bit mapper and the
// interface-select register live outside and use map_sel and map_load
`timescale 1ns/1ps

module tpm_core #(
   parameter int IFACE_W = tpm_pkg::IFACE_W,
   parameter int SMP_W = tpm_pkg::SMP_W
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   // register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [tpm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tpm_pkg::DATA_W-1:0] reg_wdata,
   output logic [tpm_pkg::DATA_W-1:0] reg_rdata,
   // output bit map control
   input wire logic [IFACE_W-1:0] iface_sel,
   output logic [IFACE_W-1:0] map_sel,
   output logic map_load,
   // converter samples in
   input wire logic smp_valid,
   input wire logic [SMP_W-1:0] smp_a,
   input wire logic [SMP_W-1:0] smp_b,
   // samples toward the bit mapper
   output logic out_valid,
   output logic [SMP_W-1:0] out_a,
   output logic [SMP_W-1:0] out_b
);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   if (SMP_W != tpm_pkg::SMP_W || IFACE_W < 1) begin : g_bad_param
      $error("unsupported sample or interface width");
   end

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic wr_load;
   logic wr_lo;
   logic wr_mid;
   logic wr_hi;

   assign wr_load = reg_wr_en && reg_addr == tpm_pkg::ADDR_MAP_LOAD;
   assign wr_lo = reg_wr_en && reg_addr == tpm_pkg::ADDR_PAT_LO;
   assign wr_mid = reg_wr_en && reg_addr == tpm_pkg::ADDR_PAT_MID;
   assign wr_hi = reg_wr_en && reg_addr == tpm_pkg::ADDR_PAT_HI;

   // ----------------------------------------------------------------
   // map load strobe: high then low completes the load
   // ----------------------------------------------------------------
   logic map_load_strobe_r;
   logic map_load_r;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         map_load_strobe_r <= 1'b0;
      end else if (ce && wr_load) begin
         map_load_strobe_r <= reg_wdata[tpm_pkg::MAP_LOAD_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         map_load_r <= 1'b0;
      end else if (ce) begin
         map_load_r <= wr_load && map_load_strobe_r
            && !reg_wdata[tpm_pkg::MAP_LOAD_BIT]; // RULE1
      end
   end

   assign map_load = map_load_r;

   // ----------------------------------------------------------------
   // mapping selection latched on load
   // ----------------------------------------------------------------
   logic [IFACE_W-1:0] map_sel_r;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         map_sel_r <= IFACE_W'(tpm_pkg::IFACE_RESET);
      end else if (ce && map_load_r) begin
         map_sel_r <= iface_sel; // RULE2
      end
   end

   assign map_sel = map_sel_r;

   // ----------------------------------------------------------------
   // pattern registers; a write in the load cycle wins over the clear
   // ----------------------------------------------------------------
   logic [7:0] pat_lo_r;
   logic [7:0] pat_mid_r;
   logic [7:0] pat_hi_r;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pat_lo_r <= tpm_pkg::REG_RESET;
      end else if (ce) begin
         if (wr_lo) begin
            pat_lo_r <= reg_wdata;
         end else if (map_load_r) begin
            pat_lo_r <= tpm_pkg::REG_RESET; // RULE3
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pat_mid_r <= tpm_pkg::REG_RESET;
      end else if (ce) begin
         if (wr_mid) begin
            pat_mid_r <= reg_wdata;
         end else if (map_load_r) begin
            pat_mid_r <= tpm_pkg::REG_RESET; // RULE3
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pat_hi_r <= tpm_pkg::REG_RESET;
      end else if (ce) begin
         if (wr_hi) begin
            pat_hi_r <= reg_wdata;
         end else if (map_load_r) begin
            pat_hi_r <= tpm_pkg::REG_RESET; // RULE3
         end
      end
   end

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   logic [tpm_pkg::PAT_W-1:0] pattern_value;
   logic [tpm_pkg::SEL_W-1:0] first_channel_pattern_select;
   logic [tpm_pkg::SEL_W-1:0] second_channel_pattern_select;
   logic [tpm_pkg::SEL_W-1:0] sel_arr [tpm_pkg::NUM_CH];
   logic [SMP_W-1:0] smp_in_arr [tpm_pkg::NUM_CH];
   logic [SMP_W-1:0] smp_out_arr [tpm_pkg::NUM_CH];

   assign pattern_value = {pat_hi_r[tpm_pkg::PAT_HI_MSB:0],
                           pat_mid_r, pat_lo_r}; // RULE13
   assign second_channel_pattern_select =
      pat_hi_r[tpm_pkg::SEL_B_MSB:tpm_pkg::SEL_B_LSB]; // RULE6
   assign first_channel_pattern_select =
      pat_hi_r[tpm_pkg::SEL_A_MSB:tpm_pkg::SEL_A_LSB]; // RULE7
   assign sel_arr[0] = first_channel_pattern_select;
   assign sel_arr[1] = second_channel_pattern_select;
   assign smp_in_arr[0] = smp_a;
   assign smp_in_arr[1] = smp_b;

   // ----------------------------------------------------------------
   // per-channel pattern insertion ahead of the mapper
   // ----------------------------------------------------------------
   for (genvar ch = 0; ch < tpm_pkg::NUM_CH; ch++) begin : g_ch
      tpm_chan_gen #(
         .PAT_W(tpm_pkg::PAT_W),
         .SMP_W(SMP_W)
      ) u_gen (
         .ref_clk(ref_clk),
         .resetn(resetn),
         .ce(ce),
         .sel(sel_arr[ch]),
         .pattern(pattern_value),
         .smp_valid(smp_valid),
         .smp_in(smp_in_arr[ch]),
         .smp_out(smp_out_arr[ch])
      ); // RULE11 RULE12
   end

   assign out_a = smp_out_arr[0];
   assign out_b = smp_out_arr[1];

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         out_valid <= 1'b0;
      end else if (ce) begin
         out_valid <= smp_valid;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = tpm_pkg::RDATA_UNMAPPED;
      unique case (reg_addr)
         tpm_pkg::ADDR_MAP_LOAD: rdata_nxt = {7'h00, map_load_strobe_r};
         tpm_pkg::ADDR_PAT_LO: rdata_nxt = pat_lo_r;
         tpm_pkg::ADDR_PAT_MID: rdata_nxt = pat_mid_r;
         tpm_pkg::ADDR_PAT_HI: rdata_nxt = pat_hi_r;
         default: rdata_nxt = tpm_pkg::RDATA_UNMAPPED;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata <= tpm_pkg::RDATA_UNMAPPED;
      end else if (ce && reg_rd_en) begin
         reg_rdata <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk iff ce);
   endclocking
   default disable iff (!resetn);

   logic [SMP_W-1:0] pat_top;
   assign pat_top = pattern_value[tpm_pkg::PAT_W-1 -: SMP_W];

   property p_load_pulse;
      map_load_r |-> $past(map_load_strobe_r) && !map_load_strobe_r;
   endproperty
   a_load_pulse: assert property (p_load_pulse) // RULE1
      else $error("map load without a high then low strobe");

   property p_load_sel;
      map_load_r |=> map_sel_r == $past(iface_sel);
   endproperty
   a_load_sel: assert property (p_load_sel) // RULE2
      else $error("mapping not latched on map load");

   property p_sel_hold;
      !map_load_r |=> $stable(map_sel_r);
   endproperty
   a_sel_hold: assert property (p_sel_hold) // RULE1
      else $error("mapping changed without a completed load");

   property p_clear;
      (map_load_r && !reg_wr_en) |=> pattern_value == '0 && pat_hi_r == '0;
   endproperty
   a_clear: assert property (p_clear) // RULE3
      else $error("map load did not clear pattern registers");

   property p_const_a;
      (smp_valid && first_channel_pattern_select == tpm_pkg::SEL_CONST)
         |=> out_valid && out_a == $past(pat_top);
   endproperty
   a_const_a: assert property (p_const_a) // RULE10
      else $error("first channel constant pattern wrong");

   property p_const_b;
      (smp_valid && second_channel_pattern_select == tpm_pkg::SEL_CONST)
         |=> out_b == $past(pat_top);
   endproperty
   a_const_b: assert property (p_const_b) // RULE4
      else $error("second channel constant pattern not msb aligned");

   property p_normal_a;
      (smp_valid && first_channel_pattern_select == tpm_pkg::SEL_NORMAL)
         |=> out_a == $past(smp_a);
   endproperty
   a_normal_a: assert property (p_normal_a) // RULE8
      else $error("first channel normal samples altered");

   property p_sel_b_field;
      (wr_hi && !map_load_r) |=> second_channel_pattern_select
         == $past(reg_wdata[tpm_pkg::SEL_B_MSB:tpm_pkg::SEL_B_LSB]);
   endproperty
   a_sel_b_field: assert property (p_sel_b_field) // RULE6
      else $error("second channel selector not taken from bits 7:5");

   property p_sel_a_field;
      wr_hi |=> first_channel_pattern_select
         == $past(reg_wdata[tpm_pkg::SEL_A_MSB:tpm_pkg::SEL_A_LSB]);
   endproperty
   a_sel_a_field: assert property (p_sel_a_field) // RULE7
      else $error("first channel selector not taken from bits 4:2");

   property p_pat_lo;
      wr_lo |=> pattern_value[7:0] == $past(reg_wdata);
   endproperty
   a_pat_lo: assert property (p_pat_lo) // RULE13
      else $error("pattern low byte not assembled");

   c_map_load: cover property (map_load_r);
   c_ramp_a: cover property (smp_valid
      && first_channel_pattern_select == tpm_pkg::SEL_RAMP [*3]);
   c_const_b: cover property (smp_valid
      && second_channel_pattern_select == tpm_pkg::SEL_CONST);
endmodule

// file: common/tpm_pkg.sv
// tpm_pkg: constants of the output test-pattern and map-load block
// assumes: 8-bit registers reached through the serial control port decoder
//
// Overview of operation
// RULE1 - map load pulses high then low to apply
// RULE2 - map load latches mapping for selected interface
// RULE3 - map load clears earlier writes; program it first
// RULE4 - constant pattern aligned MSB to output MSB
// RULE5 - software sets step 10000 for 14-bit ramp
// RULE6 - bits 7:5 select second channel pattern
// RULE7 - bits 4:2 select first channel pattern
// RULE8 - code 000 passes samples; others unused
// RULE9 - code 010 outputs ramp stepping by pattern
// RULE10 - code 011 outputs fixed pattern every sample
// RULE11 - pattern inserted before mapper at native resolution
// RULE12 - patterns identical in every output format
// RULE13 - pattern built from three registers low to high
// RULE14 - ramp advances once per sample, wraps around

package tpm_pkg;
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_MAP_LOAD = 8'h13;
   localparam logic [7:0] ADDR_PAT_LO = 8'h14;
   localparam logic [7:0] ADDR_PAT_MID = 8'h15;
   localparam logic [7:0] ADDR_PAT_HI = 8'h16;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MAP_LOAD_BIT = 0;
   localparam int SEL_B_MSB = 7;
   localparam int SEL_B_LSB = 5;
   localparam int SEL_A_MSB = 4;
   localparam int SEL_A_LSB = 2;
   localparam int PAT_HI_MSB = 1;
   // ----------------------------------------------------------------
   // widths and codes
   // ----------------------------------------------------------------
   localparam int PAT_W = 18;
   localparam int SMP_W = 14;
   localparam int SEL_W = 3;
   localparam int IFACE_W = 3;
   localparam int NUM_CH = 2;
   localparam logic [2:0] SEL_NORMAL = 3'h0;
   localparam logic [2:0] SEL_RAMP = 3'h2;
   localparam logic [2:0] SEL_CONST = 3'h3;
   localparam logic [17:0] RAMP_STEP_NATIVE = 18'h00010;
   localparam logic [2:0] IFACE_RESET = 3'h0;
endpackage

// file: src/tpm_chan_gen.sv
// tpm_chan_gen: one channel of the test-pattern source
// assumes: samples and selector come from logic on ref_clk
`timescale 1ns/1ps

module tpm_chan_gen #(
   parameter int PAT_W = 18,
   parameter int SMP_W = 14
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ce,
   // configuration
   input wire logic [2:0] sel,
   input wire logic [PAT_W-1:0] pattern,
   // sample stream
   input wire logic smp_valid,
   input wire logic [SMP_W-1:0] smp_in,
   output logic [SMP_W-1:0] smp_out
);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   if (SMP_W > PAT_W || SMP_W < 1) begin : g_bad_width
      $error("sample width must not exceed pattern width");
   end

   // ----------------------------------------------------------------
   // ramp accumulator
   // ----------------------------------------------------------------
   logic [PAT_W-1:0] acc_r;
   logic [PAT_W-1:0] acc_nxt;

   assign acc_nxt = acc_r + pattern; // RULE14

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         acc_r <= '0;
      end else if (ce) begin
         if (sel != tpm_pkg::SEL_RAMP) begin
            acc_r <= '0;
         end else if (smp_valid) begin
            acc_r <= acc_nxt; // RULE9
         end
      end
   end

   // ----------------------------------------------------------------
   // output selection, native resolution from the msb
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         smp_out <= '0;
      end else if (ce && smp_valid) begin
         case (sel)
            tpm_pkg::SEL_RAMP: smp_out <= acc_r[PAT_W-1 -: SMP_W]; // RULE9
            tpm_pkg::SEL_CONST: begin
               smp_out <= pattern[PAT_W-1 -: SMP_W]; // RULE10 RULE4
            end
            default: smp_out <= smp_in; // RULE8
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_ramp_step; // RULE14
      @(posedge ref_clk iff ce) disable iff (!resetn)
      (sel == tpm_pkg::SEL_RAMP && smp_valid) |=> acc_r == $past(acc_nxt);
   endproperty
   a_ramp_step: assert property (p_ramp_step) // RULE14
      else $error("ramp accumulator did not advance by the step");

   property p_ramp_out; // RULE9
      @(posedge ref_clk iff ce) disable iff (!resetn)
      (sel == tpm_pkg::SEL_RAMP && smp_valid)
         |=> smp_out == $past(acc_r[PAT_W-1 -: SMP_W]);
   endproperty
   a_ramp_out: assert property (p_ramp_out) // RULE9
      else $error("ramp output does not match accumulator");
endmodule

// file: tb/tpm_capture.sv
// tpm_capture: capture logic at the far side of the sample output
// assumes: valid flag and both sample words arrive on ref_clk
`timescale 1ns/1ps

module tpm_capture #(
   parameter int SMP_W = 14
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // sample stream from the device
   input wire logic in_valid,
   input wire logic [SMP_W-1:0] in_a,
   input wire logic [SMP_W-1:0] in_b,
   // captured words
   output logic [SMP_W-1:0] cap_a,
   output logic [SMP_W-1:0] cap_b
);
   // ----------------------------------------------------------------
   // capture every valid word, hold otherwise
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cap_a <= '0;
         cap_b <= '0;
      end else if (in_valid) begin
         cap_a <= in_a;
         cap_b <= in_b;
      end
   end
endmodule

// file: tb/tb_top.sv
// tb_top: self-checking bench of the test-pattern and map-load block
// assumes: tpm_core as top, tpm_capture at its sample output
`timescale 1ns/1ps

module tb_top;
   typedef struct packed {
      logic [2:0] sa;
      logic [2:0] sb;
      logic [17:0] pat;
      logic [13:0] ia;
      logic [13:0] ib;
      logic [13:0] ea;
      logic [13:0] eb;
   } tpm_row_s;
   localparam tpm_row_s ROWS [7] = '{
      '{3'h0, 3'h0, 18'h3ffff, 14'h0123, 14'h3abc, 14'h0123, 14'h3abc},
      '{3'h3, 3'h3, 18'h2a5a4, 14'h0123, 14'h3abc, 14'h2a5a, 14'h2a5a},
      '{3'h3, 3'h0, 18'h0c3f0, 14'h1111, 14'h2222, 14'h0c3f, 14'h2222},
      '{3'h0, 3'h3, 18'h3fffc, 14'h1111, 14'h2222, 14'h1111, 14'h3fff},
      '{3'h1, 3'h4, 18'h3ffff, 14'h0555, 14'h0aaa, 14'h0555, 14'h0aaa},
      '{3'h5, 3'h6, 18'h3ffff, 14'h1234, 14'h0f0f, 14'h1234, 14'h0f0f},
      '{3'h7, 3'h1, 18'h3ffff, 14'h3210, 14'h00ff, 14'h3210, 14'h00ff}};
   logic ref_clk, resetn, ce, reg_wr_en, reg_rd_en, map_load;
   logic smp_valid, out_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [2:0] iface_sel, map_sel, exp_if;
   logic [13:0] smp_a, smp_b, out_a, out_b, cap_a, cap_b, v0, dl;
   logic [17:0] step;
   int err_count, checked, i, k;
   tpm_row_s r;

   tpm_core dut (.ref_clk, .resetn, .ce, .reg_wr_en, .reg_rd_en,
      .reg_addr, .reg_wdata, .reg_rdata, .iface_sel, .map_sel, .map_load,
      .smp_valid, .smp_a, .smp_b, .out_valid, .out_a, .out_b);
   tpm_capture cap (.ref_clk, .resetn, .in_valid(out_valid),
      .in_a(out_a), .in_b(out_b), .cap_a, .cap_b);

   // ----------------------------------------------------------------
   // clock, checks and register access
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic set_pat(input logic [17:0] p, input logic [2:0] sa,
      input logic [2:0] sb);
      wr(8'h14, p[7:0]);
      wr(8'h15, p[15:8]);
      wr(8'h16, {sb, sa, p[17:16]});
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      end_of_test;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      err_count = 0;
      checked = 0;
      resetn = 1'b0;
      ce = 1'b1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      iface_sel = 3'h0;
      smp_valid = 1'b1;
      smp_a = 14'h0000;
      smp_b = 14'h0000;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      for (k = 8'h13; k <= 8'h16; k++) begin
         rd(8'(k), d);
         chk(d, 8'h00);
      end
      // map load for two interface choices
      for (i = 0; i < 2; i++) begin
         exp_if = i ? 3'h2 : 3'h5;
         iface_sel <= exp_if;
         wr(8'h14, 8'h5a);
         wr(8'h13, 8'h01);
         #1 chk(map_load, 1'b0);
         wr(8'h13, 8'h00);
         #1 chk(map_load, 1'b1);
         @(posedge ref_clk);
         #1 chk(map_load, 1'b0);
         chk(map_sel, exp_if);
         rd(8'h14, d);
         chk(d, 8'h00);
         set_pat(18'h2a5a4, 3'h3, 3'h3);
         repeat (2) @(posedge ref_clk);
         #1 chk(cap_a, 14'h2a5a);
      end
      // ordinary cases from the table
      for (i = 0; i < 7; i++) begin
         r = ROWS[i];
         smp_a <= r.ia;
         smp_b <= r.ib;
         set_pat(r.pat, r.sa, r.sb);
         repeat (2) @(posedge ref_clk);
         #1 chk(cap_a, r.ea);
         chk(cap_b, r.eb);
         rd(8'h16, d);
         chk(d, {r.sb, r.sa, r.pat[17:16]});
      end
      // ramp up by one, then down by one with wrap
      for (i = 0; i < 2; i++) begin
         step = i ? 18'h3fff0 : 18'h00010;
         dl = i ? 14'h3fff : 14'h0001;
         set_pat(step, 3'h2, 3'h2);
         repeat (3) @(posedge ref_clk);
         #1 v0 = cap_a;
         for (k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            v0 = v0 + dl;
            #1 chk(cap_a, v0);
            chk(cap_b, cap_a);
         end
         smp_valid <= 1'b0;
         repeat (3) @(posedge ref_clk);
         #1 chk(out_valid, 1'b0);
         chk(cap_a, 14'(v0 + dl));
         smp_valid <= 1'b1;
         repeat (2) @(posedge ref_clk);
         #1 chk(cap_a, 14'(v0 + dl + dl));
         v0 = out_a;
         ce <= 1'b0;
         repeat (3) @(posedge ref_clk);
         #1 chk(out_a, v0);
         ce <= 1'b1;
         repeat (2) @(posedge ref_clk);
         #1 chk(cap_a, 14'(v0 + dl));
      end
      // refused writes and a reset in mid-run
      wr(8'h13, 8'hfe);
      rd(8'h13, d);
      chk(d, 8'h00);
      chk(map_load, 1'b0);
      wr(8'h20, 8'h77);
      rd(8'h20, d);
      chk(d, 8'h00);
      wr(8'h15, 8'h3c);
      rd(8'h15, d);
      chk(d, 8'h3c);
      @(posedge ref_clk);
      resetn <= 1'b0;
      @(posedge ref_clk);
      resetn <= 1'b1;
      rd(8'h15, d);
      chk(d, 8'h00);
      chk(map_sel, 3'h0);
      end_of_test;
   end
endmodule
